// [logic/pot_spi_pkg.sv]
// constants, types and register layout for the four-channel pot spi slave
// How it works
// - shutdown opens every resistor array and grounds every wiper terminal.
// - wiper registers keep their value through shutdown and return afterwards.
// - normal only when shutdown pin high and shutdown bit one, else shutdown.
// - serial interface and all registers stay usable during shutdown.
// - read data leaves on falling serial clock edges while select is low.
// - input bits are sampled on rising serial clock edges while select low.
// - select high releases the output; standby unless a stored write runs.
// - seven-bit wiper code picks the tap, zero at ground, 7fh at supply.
// - reset sets wipers to 40h, then reloads them from initial values.
// - addresses zero to three select channels zero to three.
// - addresses four to six general bytes, seven reserved, eight access control.
// - volatile select zero reaches initial value plus wiper; one only wiper.
// - shutdown bit written zero forces shutdown; resets to one.
// - busy bit is one during stored write; then wiper, initial, control writes rejected.
// - spi mode zero, device is slave only.
// - every byte travels most significant bit first.
// - first byte must match the identification byte, else not accepted.
// - second byte holds instruction nibble high and address nibble low.
// - instruction 1011 reads, 1100 writes, all others invalid.
// - write pointer advances per data byte and wraps from six to zero.
// - stored write starts at select rising edge and lasts up to 20 ms.
// - reads continue while clocked, pointer increments and wraps after six.
package pot_spi_pkg;
  // --------------------------------------------------------------------------
  // timing
  // --------------------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS   = 10;
  localparam int unsigned NV_WRITE_MS     = 20;
  localparam int unsigned NV_WRITE_CYCLES = NV_WRITE_MS * 1000000 / CLK_PERIOD_NS;
  localparam int unsigned RECALL_US       = 1;
  localparam int unsigned RECALL_CYCLES   = RECALL_US * 1000 / CLK_PERIOD_NS;
  // --------------------------------------------------------------------------
  // protocol
  // --------------------------------------------------------------------------
  localparam logic [3:0] DEVICE_CODE  = 4'ha; // arbitrary value
  localparam logic [3:0] ID_LOW       = 4'h0;
  localparam logic [3:0] INSTR_READ   = 4'hb;
  localparam logic [3:0] INSTR_WRITE  = 4'hc;
  // --------------------------------------------------------------------------
  // register map
  // --------------------------------------------------------------------------
  localparam logic [3:0] ADDR_CH_LAST = 4'h3;
  localparam logic [3:0] ADDR_GP_LAST = 4'h6;
  localparam logic [3:0] ADDR_RSVD    = 4'h7;
  localparam logic [3:0] ADDR_ACR     = 4'h8;
  localparam int unsigned ACR_VOL_BIT  = 7;
  localparam int unsigned ACR_SHUTDOWN_N_BIT = 6;
  localparam int unsigned ACR_WIP_BIT  = 5;
  localparam logic        VOL_RESET    = 1'b0;
  localparam logic        SHUTDOWN_N_RESET   = 1'b1;
  localparam logic [6:0]  WIPER_RESET  = 7'h40;
  localparam logic [7:0]  NV_RESET     = 8'h40;
  localparam int unsigned NV_WORDS     = 7;
  localparam int unsigned CHANNELS     = 4;

  typedef enum logic [2:0] {ST_IDLE, ST_ID, ST_CMD, ST_WRITE, ST_READ, ST_IGNORE} spi_state_t;
endpackage : pot_spi_pkg

// [logic/pin_sync.sv]
// two-flop synchroniser for pins arriving from outside the core clock
`timescale 1ns/1ps
module pin_sync #(
  parameter int unsigned W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         core_clk,
  input  wire logic         srst,
  input  wire logic         clk_en,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  // --------------------------------------------------------------------------
  // per-bit stages
  // --------------------------------------------------------------------------
  logic [W-1:0] meta_q;

  for (genvar i = 0; i < W; i++) begin : g_bit
    // first stage is read only by the second
    always_ff @(posedge core_clk) begin
      if (srst) begin
        meta_q[i]   <= RST_VAL[i];
        sync_out[i] <= RST_VAL[i];
      end else if (clk_en) begin
        meta_q[i]   <= async_in[i];
        sync_out[i] <= meta_q[i];
      end
    end
  end
endmodule : pin_sync

// [logic/quad_pot_spi_register_slave.sv]
// spi mode 0 register slave for a four-channel digital potentiometer
`timescale 1ns/1ps
module quad_pot_spi_register_slave #(
  parameter int unsigned NV_WRITE_CYCLES = pot_spi_pkg::NV_WRITE_CYCLES
) (
  input  wire logic             core_clk,
  input  wire logic             srst,
  input  wire logic             clk_en,
  input  wire logic             sck,
  input  wire logic             cs_n,
  input  wire logic             sdi,
  input  wire logic             shutdown_n,
  output logic                  sdo_o,
  output logic                  sdo_oe_n,
  output logic [3:0][6:0]       wiper_code,
  output logic                  array_open,
  output logic                  wiper_to_gnd,
  output logic                  standby,
  output logic                  nv_write_pending
);
  // --------------------------------------------------------------------------
  // pin synchronisation and edge detection
  // --------------------------------------------------------------------------
  logic [3:0] pins_s;
  logic       sck_s, cs_s, sdi_s, shutdown_n_pin_s;
  logic       sck_prev_q, cs_prev_q;
  logic       sck_rise, sck_fall, cs_rise, cs_fall;

  // cs resets low so a select held low from reset never makes a falling edge
  pin_sync #(.W(4), .RST_VAL(4'h0)) u_sync (
    .core_clk (core_clk),
    .srst     (srst),
    .clk_en   (clk_en),
    .async_in ({sck, cs_n, sdi, shutdown_n}),
    .sync_out (pins_s)
  );
  assign {sck_s, cs_s, sdi_s, shutdown_n_pin_s} = pins_s;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      sck_prev_q <= 1'b0;
      cs_prev_q  <= 1'b0;
    end else if (clk_en) begin
      sck_prev_q <= sck_s;
      cs_prev_q  <= cs_s;
    end
  end

  assign sck_rise = clk_en && !cs_s && sck_s && !sck_prev_q;
  assign sck_fall = clk_en && !cs_s && !sck_s && sck_prev_q;
  assign cs_rise  = clk_en && cs_s && !cs_prev_q;
  assign cs_fall  = clk_en && !cs_s && cs_prev_q;

  // --------------------------------------------------------------------------
  // register storage
  // --------------------------------------------------------------------------
  logic [6:0] wiper_q [pot_spi_pkg::CHANNELS];
  logic [7:0] nv_q [pot_spi_pkg::NV_WORDS];
  logic       vol_q, shutdown_n_bit_q, wip_q;
  logic       nv_pend_q;
  logic [3:0] nv_addr_q;
  logic [7:0] nv_data_q;
  logic [31:0] wip_cnt_q;
  logic        recall_q;
  logic [31:0] recall_cnt_q;

  // --------------------------------------------------------------------------
  // serial state machine
  // --------------------------------------------------------------------------
  pot_spi_pkg::spi_state_t state_q;
  logic [2:0] bit_q;
  logic [2:0] fall_q;
  logic [7:0] rx_q;
  logic [7:0] rx_byte;
  logic       byte_done;
  logic [3:0] ptr_q;
  logic [3:0] ptr_next;
  logic [7:0] tx_q;
  logic [7:0] rd_data;
  logic       sdo_bit_q;
  logic       wr_ok;

  assign rx_byte   = {rx_q[6:0], sdi_s};
  assign byte_done = sck_rise && (bit_q == 3'h7);
  assign ptr_next  = (ptr_q >= pot_spi_pkg::ADDR_GP_LAST) ? 4'h0 : ptr_q + 4'h1;
  assign wr_ok     = byte_done && (state_q == pot_spi_pkg::ST_WRITE) && !wip_q;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      bit_q <= 3'h0;
      rx_q  <= 8'h00;
    end else if (cs_fall) begin
      bit_q <= 3'h0;
    end else if (sck_rise) begin
      bit_q <= bit_q + 3'h1;
      rx_q  <= rx_byte;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      state_q <= pot_spi_pkg::ST_IDLE;
      ptr_q   <= 4'h0;
    end else if (clk_en) begin
      if (cs_s) begin
        state_q <= pot_spi_pkg::ST_IDLE;
      end else if (cs_fall) begin
        state_q <= pot_spi_pkg::ST_ID;
      end else begin
        unique case (state_q)
          pot_spi_pkg::ST_IDLE: begin
            state_q <= pot_spi_pkg::ST_IDLE;
          end
          pot_spi_pkg::ST_ID: begin
            if (byte_done) begin
              if (rx_byte == {pot_spi_pkg::DEVICE_CODE, pot_spi_pkg::ID_LOW}) begin
                state_q <= pot_spi_pkg::ST_CMD;
              end else begin
                state_q <= pot_spi_pkg::ST_IGNORE;
              end
            end
          end
          pot_spi_pkg::ST_CMD: begin
            if (byte_done) begin
              ptr_q <= rx_byte[3:0];
              if (rx_byte[7:4] == pot_spi_pkg::INSTR_READ) begin
                state_q <= pot_spi_pkg::ST_READ;
              end else if (rx_byte[7:4] == pot_spi_pkg::INSTR_WRITE) begin
                state_q <= pot_spi_pkg::ST_WRITE;
              end else begin
                state_q <= pot_spi_pkg::ST_IGNORE;
              end
            end
          end
          pot_spi_pkg::ST_WRITE: begin
            if (byte_done) begin
              ptr_q <= ptr_next;
            end
          end
          pot_spi_pkg::ST_READ: begin
            if (sck_fall && fall_q == 3'h7) begin
              ptr_q <= ptr_next;
            end
          end
          pot_spi_pkg::ST_IGNORE: begin
            state_q <= pot_spi_pkg::ST_IGNORE;
          end
        endcase
      end
    end
  end

  // --------------------------------------------------------------------------
  // read path
  // --------------------------------------------------------------------------
  always_comb begin
    rd_data = 8'h00;
    if (ptr_q <= pot_spi_pkg::ADDR_CH_LAST) begin
      rd_data = vol_q ? {1'b0, wiper_q[ptr_q[1:0]]} : nv_q[ptr_q[2:0]];
    end else if (ptr_q <= pot_spi_pkg::ADDR_GP_LAST) begin
      rd_data = nv_q[ptr_q[2:0]];
    end else if (ptr_q == pot_spi_pkg::ADDR_ACR) begin
      rd_data[pot_spi_pkg::ACR_VOL_BIT]  = vol_q;
      rd_data[pot_spi_pkg::ACR_SHUTDOWN_N_BIT] = shutdown_n_bit_q;
      rd_data[pot_spi_pkg::ACR_WIP_BIT]  = wip_q;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      fall_q    <= 3'h0;
      tx_q      <= 8'h00;
      sdo_bit_q <= 1'b1;
    end else if (clk_en) begin
      if (state_q != pot_spi_pkg::ST_READ) begin
        fall_q    <= 3'h0;
        sdo_bit_q <= 1'b1;
      end else if (sck_fall) begin
        // first falling edge after the command byte presents the msb
        fall_q <= fall_q + 3'h1;
        if (fall_q == 3'h0) begin
          sdo_bit_q <= rd_data[7];
          tx_q      <= {rd_data[6:0], 1'b0};
        end else begin
          sdo_bit_q <= tx_q[7];
          tx_q      <= {tx_q[6:0], 1'b0};
        end
      end
    end
  end

  // open drain: the pad is only ever pulled low
  assign sdo_o    = 1'b0;
  assign sdo_oe_n = !((state_q == pot_spi_pkg::ST_READ) && !cs_s && !sdo_bit_q);

  // --------------------------------------------------------------------------
  // write path and access control
  // --------------------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (srst) begin
      vol_q      <= pot_spi_pkg::VOL_RESET;
      shutdown_n_bit_q <= pot_spi_pkg::SHUTDOWN_N_RESET;
    end else if (wr_ok && ptr_q == pot_spi_pkg::ADDR_ACR) begin
      vol_q      <= rx_byte[pot_spi_pkg::ACR_VOL_BIT];
      shutdown_n_bit_q <= rx_byte[pot_spi_pkg::ACR_SHUTDOWN_N_BIT];
    end
  end

  // wipers: 40h at reset, reloaded once the recall delay has passed
  always_ff @(posedge core_clk) begin
    if (srst) begin
      recall_q     <= 1'b1;
      recall_cnt_q <= 32'h0;
      for (int i = 0; i < pot_spi_pkg::CHANNELS; i++) begin
        wiper_q[i] <= pot_spi_pkg::WIPER_RESET;
      end
    end else if (clk_en) begin
      if (recall_q) begin
        recall_cnt_q <= recall_cnt_q + 32'h1;
        if (recall_cnt_q == 32'(pot_spi_pkg::RECALL_CYCLES - 1)) begin
          recall_q <= 1'b0;
          for (int i = 0; i < pot_spi_pkg::CHANNELS; i++) begin
            wiper_q[i] <= nv_q[i][6:0];
          end
        end
      end else if (wr_ok && ptr_q <= pot_spi_pkg::ADDR_CH_LAST) begin
        wiper_q[ptr_q[1:0]] <= rx_byte[6:0];
      end
    end
  end

  // one pending non-volatile byte per transaction; the last one written wins
  always_ff @(posedge core_clk) begin
    if (srst) begin
      nv_pend_q <= 1'b0;
      nv_addr_q <= 4'h0;
      nv_data_q <= 8'h00;
    end else if (cs_rise || cs_fall) begin
      nv_pend_q <= 1'b0;
    end else if (wr_ok && ptr_q <= pot_spi_pkg::ADDR_GP_LAST &&
                 (!vol_q || ptr_q > pot_spi_pkg::ADDR_CH_LAST)) begin
      nv_pend_q <= 1'b1;
      nv_addr_q <= ptr_q;
      nv_data_q <= rx_byte;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      wip_q     <= 1'b0;
      wip_cnt_q <= 32'h0;
      for (int i = 0; i < pot_spi_pkg::NV_WORDS; i++) begin
        nv_q[i] <= pot_spi_pkg::NV_RESET;
      end
    end else if (clk_en) begin
      if (cs_rise && nv_pend_q && !wip_q) begin
        wip_q               <= 1'b1;
        wip_cnt_q           <= 32'h0;
        nv_q[nv_addr_q[2:0]] <= nv_data_q;
      end else if (wip_q) begin
        wip_cnt_q <= wip_cnt_q + 32'h1;
        if (wip_cnt_q == 32'(NV_WRITE_CYCLES - 1)) begin
          wip_q <= 1'b0;
        end
      end
    end
  end

  // --------------------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------------------
  for (genvar c = 0; c < pot_spi_pkg::CHANNELS; c++) begin : g_wiper
    assign wiper_code[c] = wiper_q[c];
  end

  assign array_open       = !(shutdown_n_pin_s && shutdown_n_bit_q);
  assign wiper_to_gnd     = array_open;
  assign standby          = cs_s && !wip_q;
  assign nv_write_pending = wip_q;

  // --------------------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------------------
  logic srst_prev_q;
  always_ff @(posedge core_clk) begin
    srst_prev_q <= srst;
  end

  id_reject_a: assert property (@(posedge core_clk) disable iff (srst)
    (byte_done && state_q == pot_spi_pkg::ST_ID && rx_byte != 8'ha0)
      |=> (state_q == pot_spi_pkg::ST_IGNORE || cs_s) && sdo_oe_n)
    else $error("bad id byte not ignored");

  ignore_quiet_a: assert property (@(posedge core_clk) disable iff (srst)
    (state_q == pot_spi_pkg::ST_IGNORE) |-> sdo_oe_n)
    else $error("output driven while ignoring");

  sdo_release_a: assert property (@(posedge core_clk) disable iff (srst)
    $rose(cs_s) |-> sdo_oe_n ##1 sdo_oe_n)
    else $error("output not released on deselect");

  shutdown_pin_a: assert property (@(posedge core_clk) disable iff (srst)
    (!shutdown_n_pin_s || !shutdown_n_bit_q) |-> array_open && wiper_to_gnd)
    else $error("shutdown not applied");

  wiper_keep_a: assert property (@(posedge core_clk) disable iff (srst)
    (array_open && !recall_q && !wr_ok) |=> $stable(wiper_q[0]) && $stable(wiper_q[3]))
    else $error("wiper changed in shutdown");

  wip_block_a: assert property (@(posedge core_clk) disable iff (srst)
    (wip_q && byte_done && state_q == pot_spi_pkg::ST_WRITE)
      |=> $stable(vol_q) && $stable(shutdown_n_bit_q) && $stable(wiper_q[0]))
    else $error("write accepted while busy");

  nv_commit_a: assert property (@(posedge core_clk) disable iff (srst)
    (cs_rise && nv_pend_q) |=> wip_q [*8])
    else $error("stored write did not start");

  ptr_wrap_a: assert property (@(posedge core_clk) disable iff (srst)
    (byte_done && state_q == pot_spi_pkg::ST_WRITE && ptr_q == 4'h6 && !cs_s) |=> ptr_q == 4'h0)
    else $error("write pointer did not wrap");

  powerup_a: assert property (@(posedge core_clk)
    (srst_prev_q && !srst) |-> wiper_q[0] == 7'h40 && wiper_q[2] == 7'h40 && recall_q)
    else $error("wipers not at mid code after reset");

  read_cover_c: cover property (@(posedge core_clk) disable iff (srst)
    state_q == pot_spi_pkg::ST_READ && sck_fall && fall_q == 3'h7);
  write_cover_c: cover property (@(posedge core_clk) disable iff (srst) wr_ok);
  nv_cover_c: cover property (@(posedge core_clk) disable iff (srst) $fell(wip_q));
  ignore_cover_c: cover property (@(posedge core_clk) disable iff (srst)
    state_q == pot_spi_pkg::ST_IGNORE);
endmodule : quad_pot_spi_register_slave

// [verification/spi_host_model.sv]
// behavioural spi mode 0 host that drives the slave's serial pins
`timescale 1ns/1ps
module spi_host_model #(
  parameter realtime HALF_NS = 62.5
) (
  output logic     sck,
  output logic     cs_n,
  output logic     sdi,
  input  wire logic sdo_line
);
  logic [7:0] rx_byte;
  logic       rx_mark;
  event       rx_ev;

  // select starts low so the first frame after power-up has no falling edge
  initial begin
    sck  = 1'b0;
    cs_n = 1'b0;
    sdi  = 1'b0;
    rx_mark = 1'b0;
  end

  // one byte, msb first; sdi moves while sck is low, sdo taken at the rise
  task automatic xfer(input logic [7:0] tx, input logic mark);
    for (int i = 7; i >= 0; i--) begin
      sdi = tx[i];
      #(HALF_NS);
      sck = 1'b1;
      rx_byte[i] = sdo_line;
      #(HALF_NS);
      sck = 1'b0;
    end
    rx_mark = mark;
    ->rx_ev;
  endtask : xfer

  task automatic frame(input logic [7:0] id, input logic [7:0] cmd, input int n,
                       input logic [7:0] d[8], input logic mark);
    cs_n = 1'b0;
    #(4 * HALF_NS);
    xfer(id, 1'b0);
    xfer(cmd, 1'b0);
    for (int i = 0; i < n; i++) begin
      xfer(d[i], mark);
    end
    #(4 * HALF_NS);
    cs_n = 1'b1;
    // sdi is meaningless between frames, so it does not keep the last bit
    sdi = ~sdi;
    #2000;
  endtask : frame
endmodule : spi_host_model

// [verification/tb_quad_pot_spi_register_slave.sv]
// self-checking bench for the four-channel pot spi register slave
`timescale 1ns/1ps
module tb_quad_pot_spi_register_slave;
  localparam int unsigned NVW = 2000;
  localparam logic [7:0]  ID  = {pot_spi_pkg::DEVICE_CODE, pot_spi_pkg::ID_LOW};
  logic            core_clk, srst, clk_en, shutdown_n;
  wire logic       sck, cs_n, sdi, sdo_line;
  logic            sdo_o, sdo_oe_n, array_open, wiper_to_gnd, standby, nv_write_pending;
  logic [3:0][6:0] wiper_code;
  logic [7:0]      wd[8];
  logic [7:0]      dm[8];
  logic [7:0]      sv[4];
  logic [7:0]      exp_q[$];
  logic [15:0]     seed;
  logic            watch, pulled;
  int              num_errors, compares;

  // open-drain line with its pull-up
  assign sdo_line = sdo_oe_n ? 1'b1 : sdo_o;

  quad_pot_spi_register_slave #(.NV_WRITE_CYCLES(NVW)) quad_pot_spi_register_slave_i (
    .core_clk(core_clk), .srst(srst), .clk_en(clk_en), .sck(sck), .cs_n(cs_n), .sdi(sdi),
    .shutdown_n(shutdown_n), .sdo_o(sdo_o), .sdo_oe_n(sdo_oe_n), .wiper_code(wiper_code),
    .array_open(array_open), .wiper_to_gnd(wiper_to_gnd), .standby(standby),
    .nv_write_pending(nv_write_pending));
  spi_host_model spi_host_model_i (.sck(sck), .cs_n(cs_n), .sdi(sdi), .sdo_line(sdo_line));

  // --------------------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------------------
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask : cyc

  task automatic rnd();
    for (int i = 0; i < 8; i++) begin
      wd[i] = seed[7:0];
      seed = lfsr(seed);
    end
  endtask : rnd

  task automatic wr(input logic [3:0] a, input int n);
    spi_host_model_i.frame(ID, {pot_spi_pkg::INSTR_WRITE, a}, n, wd, 1'b0);
  endtask : wr

  task automatic rd(input logic [3:0] a, input int n);
    spi_host_model_i.frame(ID, {pot_spi_pkg::INSTR_READ, a}, n, dm, 1'b1);
  endtask : rd

  // bounded wait for the stored write to finish
  task automatic wait_idle();
    for (int k = 0; k < 2 * NVW && nv_write_pending !== 1'b0; k++) begin
      cyc(1);
    end
    chk({7'h00, nv_write_pending}, 8'h00, "busy end");
  endtask : wait_idle

  task automatic report_and_stop();
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : report_and_stop

  // --------------------------------------------------------------------------
  // clock, watchdog and monitors
  // --------------------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  initial begin
    #600000;
    num_errors++;
    $display("unexpected at %0t: watchdog expired", $time);
    report_and_stop();
  end

  // read bytes are taken off the queue as the host finishes them
  initial forever begin
    @(spi_host_model_i.rx_ev);
    if (spi_host_model_i.rx_mark === 1'b1) begin
      if (exp_q.size() == 0) begin
        num_errors++;
        $display("unexpected at %0t: read byte with nothing expected", $time);
      end else begin
        chk(spi_host_model_i.rx_byte, exp_q.pop_front(), "read byte");
      end
    end
  end

  initial forever begin
    @(negedge sdo_oe_n);
    if (watch) pulled = 1'b1;
  end

  // --------------------------------------------------------------------------
  // stimulus
  // --------------------------------------------------------------------------
  initial begin
    srst = 1'b1;
    clk_en = 1'b1;
    shutdown_n = 1'b1;
    seed = 16'h2b25;
    watch = 1'b0;
    pulled = 1'b0;
    num_errors = 0;
    compares = 0;
    for (int i = 0; i < 8; i++) dm[i] = 8'hff;
    cyc(12);
    srst = 1'b0;
    cyc(2);
    for (int i = 0; i < 4; i++) chk({1'b0, wiper_code[i]}, 8'h40, "wiper reset");
    wd[0] = 8'h11;
    wr(4'h0, 1);
    chk({1'b0, wiper_code[0]}, 8'h40, "no select fall");
    chk({7'h00, nv_write_pending}, 8'h00, "no select fall busy");
    chk({6'h00, standby, sdo_oe_n}, 8'h03, "idle pins");
    exp_q.push_back(8'h40);
    rd(4'h8, 1);
    // volatile burst across all four channels, read back across the wrap
    wd[0] = 8'hc0;
    wr(4'h8, 1);
    rnd();
    wr(4'h0, 4);
    for (int i = 0; i < 4; i++) begin
      sv[i] = {1'b0, wd[i][6:0]};
      chk({1'b0, wiper_code[i]}, sv[i], "wiper write");
    end
    chk({7'h00, nv_write_pending}, 8'h00, "volatile busy");
    exp_q.push_back(sv[2]);
    exp_q.push_back(sv[3]);
    repeat (3) exp_q.push_back(8'h40);
    exp_q.push_back(sv[0]);
    rd(4'h2, 6);
    // burst wrapping from six to zero; only the last stored byte is kept
    rnd();
    wr(4'h5, 3);
    sv[0] = {1'b0, wd[2][6:0]};
    chk({1'b0, wiper_code[0]}, sv[0], "wrapped write");
    chk({6'h00, nv_write_pending, standby}, 8'h02, "busy after select");
    wd[0] = 8'h00;
    wr(4'h8, 1);
    exp_q.push_back(8'he0);
    rd(4'h8, 1);
    wait_idle();
    exp_q.push_back(8'hc0);
    exp_q.push_back(sv[0]);
    rd(4'h8, 2);
    // only the last stored byte of the wrapped burst landed, at address six
    exp_q.push_back(8'h40);
    exp_q.push_back(wd[1]);
    exp_q.push_back(sv[0]);
    rd(4'h5, 3);
    exp_q.push_back(8'h00);
    rd(4'h7, 1);
    // all four pin and bit combinations; registers stay usable meanwhile
    for (int k = 0; k < 4; k++) begin
      cyc(1);
      shutdown_n = k[0];
      wd[0] = {1'b1, k[1], 6'h00};
      wr(4'h8, 1);
      rnd();
      wr(4'h1, 1);
      sv[1] = {1'b0, wd[0][6:0]};
      chk({6'h00, array_open, wiper_to_gnd}, {8{~(k[0] & k[1])}} & 8'h03, "shutdown");
      chk({1'b0, wiper_code[1]}, sv[1], "write in shutdown");
      chk({1'b0, wiper_code[0]}, sv[0], "wiper kept");
    end
    // bad identification bytes and every unused instruction are ignored
    watch = 1'b1;
    wd[0] = 8'h7f;
    // a released line reads all ones through the pull-up
    exp_q.push_back(8'hff);
    spi_host_model_i.frame({~pot_spi_pkg::DEVICE_CODE, 4'h0}, 8'hc1, 1, dm, 1'b1);
    exp_q.push_back(8'hff);
    spi_host_model_i.frame({pot_spi_pkg::DEVICE_CODE, 4'h1}, 8'hb1, 1, dm, 1'b1);
    for (int c = 0; c < 16; c++) begin
      if (c != 11 && c != 12) spi_host_model_i.frame(ID, {c[3:0], 4'h1}, 1, wd, 1'b0);
    end
    watch = 1'b0;
    chk({7'h00, pulled}, 8'h00, "sdo released");
    chk({1'b0, wiper_code[1]}, sv[1], "ignored frames");
    // stored path: initial value written also loads the wiper
    wd[0] = 8'h40;
    wr(4'h8, 1);
    rnd();
    wr(4'h2, 1);
    chk({1'b0, wiper_code[2]}, {1'b0, wd[0][6:0]}, "wiper load");
    chk({7'h00, nv_write_pending}, 8'h01, "stored write");
    wait_idle();
    exp_q.push_back(wd[0]);
    rd(4'h2, 1);
    // frozen clock enable: a whole frame passes unseen and nothing moves
    sv[2] = {1'b0, wd[0][6:0]};
    cyc(1);
    clk_en = 1'b0;
    rnd();
    wr(4'h2, 1);
    cyc(1);
    clk_en = 1'b1;
    cyc(4);
    chk({1'b0, wiper_code[2]}, sv[2], "frozen frame");
    chk({7'h00, nv_write_pending}, 8'h00, "frozen busy");
    // second reset in mid-run
    cyc(1);
    srst = 1'b1;
    cyc(2);
    srst = 1'b0;
    cyc(2);
    chk({1'b0, wiper_code[2]}, 8'h40, "wiper after reset");
    cyc(120);
    chk({1'b0, wiper_code[2]}, 8'h40, "wiper after recall");
    exp_q.push_back(8'h40);
    rd(4'h8, 1);
    chk(8'(exp_q.size()), 8'h00, "reads pending");
    report_and_stop();
  end
endmodule : tb_quad_pot_spi_register_slave
